// ===== logic/ulc_pkg.sv
// Shared constants, state encodings and carrier types for the serially loaded core.
// Assumes a single 100 MHz clock domain and a host that supplies the sync byte.
package ulc_pkg;
    // Storage sizes
    localparam int IMEM_WORDS = 16;
    localparam int DMEM_WORDS = 4;
    localparam int REG_COUNT = 16;
    localparam logic [5:0] LOAD_LAST_BYTE = 6'h3f;
    localparam logic [3:0] DUMP_LAST_BYTE = 4'hf;
    // Serial framing and timing
    localparam logic [15:0] BAUD_RESET = 16'h0001;
    localparam logic [3:0] RX_LAST_BIT = 4'h7;
    localparam logic [3:0] TX_LAST_BIT = 4'h9;
    // Core constants
    localparam logic [31:0] PC_RESET = 32'h0000_0000;
    localparam logic [31:0] PC_STEP = 32'h0000_0004;
    localparam logic [6:0] OPC_LUI = 7'h37;
    localparam logic [6:0] OPC_AUIPC = 7'h17;
    localparam logic [6:0] OPC_JAL = 7'h6f;
    localparam logic [6:0] OPC_JALR = 7'h67;
    localparam logic [6:0] OPC_BRANCH = 7'h63;
    localparam logic [6:0] OPC_LOAD = 7'h03;
    localparam logic [6:0] OPC_STORE = 7'h23;
    localparam logic [6:0] OPC_OPIMM = 7'h13;
    localparam logic [6:0] OPC_OP = 7'h33;
    localparam logic [2:0] F3_SHIFT_RIGHT = 3'h5;
    localparam logic [2:0] F3_ADD_SUB = 3'h0;

    // Controller modes
    typedef enum logic [1:0] {
        CTL_LOAD = 2'b01,
        CTL_DUMP = 2'b10
    } ulc_ctl_state_t;

    // Receiver states
    typedef enum logic [5:0] {
        RX_HUNT = 6'b000001,
        RX_MEASURE = 6'b000010,
        RX_IDLE = 6'b000100,
        RX_START = 6'b001000,
        RX_DATA = 6'b010000,
        RX_STOP = 6'b100000
    } ulc_rx_state_t;

    // Transmitter states
    typedef enum logic [1:0] {
        TX_IDLE = 2'b01,
        TX_SEND = 2'b10
    } ulc_tx_state_t;

    // One byte with its qualifier
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } ulc_byte_t;
endpackage

// ===== logic/ulc_uart_rx.sv
// Serial receiver with bit period taken from the start bit of the first frame.
// Assumes the line input is already synchronous to ref_clk_i.
`timescale 1ns/1ps
module ulc_uart_rx (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic en_i,
    // Serial line
    input wire logic rx_i,
    // Received byte and measured bit period
    output ulc_pkg::ulc_byte_t byte_o,
    output logic [15:0] bit_period_o
);
    import ulc_pkg::*;

    ulc_rx_state_t state_ff, nxt_state;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [15:0] period_ff, nxt_period;
    logic [3:0] bit_ff, nxt_bit;
    logic [7:0] shift_ff, nxt_shift;
    logic sync_ff, nxt_sync;
    ulc_byte_t out_ff, nxt_out;

    assign byte_o = out_ff;
    assign bit_period_o = period_ff;

    // Frame sequencing; the sync frame is sampled but never delivered
    always_comb
    begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_period = period_ff;
        nxt_bit = bit_ff;
        nxt_shift = shift_ff;
        nxt_sync = sync_ff;
        nxt_out = '{valid: 1'b0, data: out_ff.data};
        unique case (state_ff)
            RX_HUNT:
            begin
                if (!rx_i)
                begin
                    nxt_cnt = 16'h0001;
                    nxt_state = RX_MEASURE;
                end
            end
            // [RULE6] start bit width
            RX_MEASURE:
            begin
                if (rx_i)
                begin
                    nxt_period = cnt_ff;
                    nxt_cnt = {1'b0, cnt_ff[15:1]};
                    nxt_bit = 4'h0;
                    nxt_sync = 1'b1;
                    nxt_state = RX_DATA;
                end
                else if (cnt_ff != 16'hffff)
                begin
                    nxt_cnt = cnt_ff + 16'h0001;
                end
            end
            RX_IDLE:
            begin
                if (!rx_i)
                begin
                    nxt_cnt = {1'b0, period_ff[15:1]};
                    nxt_state = RX_START;
                end
            end
            // A start bit gone high by mid-bit is a glitch
            RX_START:
            begin
                if (cnt_ff != 16'h0000)
                    nxt_cnt = cnt_ff - 16'h0001;
                else if (rx_i)
                    nxt_state = RX_IDLE;
                else
                begin
                    nxt_cnt = period_ff - 16'h0001;
                    nxt_bit = 4'h0;
                    nxt_state = RX_DATA;
                end
            end
            // [RULE8] eight bits, LSB first
            RX_DATA:
            begin
                if (cnt_ff != 16'h0000)
                    nxt_cnt = cnt_ff - 16'h0001;
                else
                begin
                    nxt_shift = {rx_i, shift_ff[7:1]};
                    nxt_cnt = period_ff - 16'h0001;
                    nxt_bit = bit_ff + 4'h1;
                    if (bit_ff == RX_LAST_BIT)
                        nxt_state = RX_STOP;
                end
            end
            // Low stop bit is a framing error; byte dropped
            RX_STOP:
            begin
                if (cnt_ff != 16'h0000)
                    nxt_cnt = cnt_ff - 16'h0001;
                else
                begin
                    nxt_out = '{valid: rx_i & ~sync_ff, data: shift_ff};
                    nxt_sync = 1'b0;
                    nxt_state = RX_IDLE;
                end
            end
        endcase
    end

    // Registers, frozen while en_i is low
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_ff <= RX_HUNT;
            cnt_ff <= 16'h0000;
            period_ff <= BAUD_RESET;
            bit_ff <= 4'h0;
            shift_ff <= 8'h00;
            sync_ff <= 1'b0;
            out_ff <= '0;
        end
        else if (en_i)
        begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            period_ff <= nxt_period;
            bit_ff <= nxt_bit;
            shift_ff <= nxt_shift;
            sync_ff <= nxt_sync;
            out_ff <= nxt_out;
        end
    end
endmodule

// ===== logic/ulc_uart_tx.sv
// Serial transmitter: start bit, eight data bits LSB first, one stop bit.
// Assumes bit_period_i is stable during a frame and at least one.
`timescale 1ns/1ps
module ulc_uart_tx (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic en_i,
    // Byte in and bit timing
    input ulc_pkg::ulc_byte_t byte_i,
    input wire logic [15:0] bit_period_i,
    output logic ready_o,
    // Serial line
    output logic tx_o
);
    import ulc_pkg::*;

    ulc_tx_state_t state_ff, nxt_state;
    logic [9:0] shift_ff, nxt_shift;
    logic [15:0] cnt_ff, nxt_cnt;
    logic [3:0] bit_ff, nxt_bit;
    logic line_ff, nxt_line;

    assign ready_o = (state_ff == TX_IDLE);
    assign tx_o = line_ff;

    // Frame shifter; line idles high
    always_comb
    begin
        nxt_state = state_ff;
        nxt_shift = shift_ff;
        nxt_cnt = cnt_ff;
        nxt_bit = bit_ff;
        nxt_line = line_ff;
        unique case (state_ff)
            // [RULE8] 8N1 frame
            TX_IDLE:
            begin
                nxt_line = 1'b1;
                if (byte_i.valid)
                begin
                    nxt_shift = {1'b1, byte_i.data, 1'b0};
                    nxt_line = 1'b0;
                    nxt_cnt = bit_period_i - 16'h0001;
                    nxt_bit = 4'h0;
                    nxt_state = TX_SEND;
                end
            end
            TX_SEND:
            begin
                if (cnt_ff != 16'h0000)
                    nxt_cnt = cnt_ff - 16'h0001;
                else if (bit_ff == TX_LAST_BIT)
                begin
                    nxt_line = 1'b1;
                    nxt_state = TX_IDLE;
                end
                else
                begin
                    nxt_shift = {1'b1, shift_ff[9:1]};
                    nxt_line = shift_ff[1];
                    nxt_bit = bit_ff + 4'h1;
                    nxt_cnt = bit_period_i - 16'h0001;
                end
            end
        endcase
    end

    // Registers, frozen while en_i is low
    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            state_ff <= TX_IDLE;
            shift_ff <= 10'h3ff;
            cnt_ff <= 16'h0000;
            bit_ff <= 4'h0;
            line_ff <= 1'b1;
        end
        else if (en_i)
        begin
            state_ff <= nxt_state;
            shift_ff <= nxt_shift;
            cnt_ff <= nxt_cnt;
            bit_ff <= nxt_bit;
            line_ff <= nxt_line;
        end
    end
endmodule

// ===== logic/ulc_core_top.sv
// Serially loaded RV32I-subset core: load controller, dump sequencer and core.
// Assumes a host terminal on the serial pins; reset_n_i is the system reset.
//
// Functional notes
// [RULE1] After reset, wait for instruction bytes
// [RULE2] Host sends sync byte, then image
// [RULE3] Dump mode only after 64 stored bytes
// [RULE4] Any byte in dump mode starts dump; bytes received while a dump runs are ignored
// [RULE5] Separate 16-word and 4-word stores
// [RULE6] Bit period measured from sync start bit
// [RULE7] Sync byte has bit zero set
// [RULE8] Frames are 8 data, no parity, 1 stop
// [RULE9] Bytes LSB first, words in order
// [RULE10] Host pads unused slots with no-ops
// [RULE11] No FENCE, ECALL or EBREAK
// [RULE12] Every load acts as word load
// [RULE13] Every store acts as word store
// [RULE14] Only sixteen registers x0 to x15
// [RULE15] Load indicator high in load state
// [RULE16] Activity outputs high on low lines
// [RULE17] Reset indicator high during reset
// [RULE18] Host resets to load new program
// [RULE19] Dump sends sixteen bytes, stays in dump
// [RULE20] Core runs only after store is full
`timescale 1ns/1ps
module ulc_core_top (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic en_i,
    // Serial link
    input wire logic serial_receive_input_i,
    output logic serial_transmit_output_o,
    // Indicators
    output logic load_state_indicator_o,
    output logic rx_activity_indicator_o,
    output logic tx_activity_indicator_o,
    output logic reset_indicator_o
);
    import ulc_pkg::*;

    // ALU shared by register and immediate forms
    function automatic logic [31:0] ulc_alu(input logic [2:0] f3, input logic alt,
                                            input logic [31:0] a, input logic [31:0] b);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (f3)
            3'h0: r = alt ? (a - b) : (a + b);
            3'h1: r = a << b[4:0];
            3'h2: r = {31'h0, $signed(a) < $signed(b)};
            3'h3: r = {31'h0, a < b};
            3'h4: r = a ^ b;
            3'h5: r = alt ? 32'($signed(a) >>> b[4:0]) : (a >> b[4:0]);
            3'h6: r = a | b;
            3'h7: r = a & b;
        endcase
        return r;
    endfunction

    // Branch condition
    function automatic logic ulc_taken(input logic [2:0] f3, input logic [31:0] a,
                                       input logic [31:0] b);
        logic t;
        t = 1'b0;
        case (f3)
            3'h0: t = (a == b);
            3'h1: t = (a != b);
            3'h4: t = ($signed(a) < $signed(b));
            3'h5: t = ($signed(a) >= $signed(b));
            3'h6: t = (a < b);
            3'h7: t = (a >= b);
            default: t = 1'b0;
        endcase
        return t;
    endfunction

    ulc_byte_t rx_byte;
    ulc_byte_t tx_byte;
    logic [15:0] bit_period;
    logic tx_ready;
    logic tx_line;

    ulc_ctl_state_t ctl_ff, nxt_ctl;
    logic [5:0] load_cnt_ff, nxt_load_cnt;
    logic dump_busy_ff, nxt_dump_busy;
    logic [3:0] dump_idx_ff, nxt_dump_idx;
    // [RULE5] separate stores
    logic [31:0] imem_ff [IMEM_WORDS];
    logic [31:0] nxt_imem [IMEM_WORDS];
    logic [31:0] dmem_ff [DMEM_WORDS];
    logic [31:0] nxt_dmem [DMEM_WORDS];
    logic [31:0] regs_ff [REG_COUNT];
    logic [31:0] nxt_regs [REG_COUNT];
    logic [31:0] pc_ff, nxt_pc;

    // Serial receiver and transmitter
    ulc_uart_rx ulc_uart_rx_i (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .en_i(en_i),
        .rx_i(serial_receive_input_i),
        .byte_o(rx_byte),
        .bit_period_o(bit_period)
    );

    ulc_uart_tx ulc_uart_tx_i (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .en_i(en_i),
        .byte_i(tx_byte),
        .bit_period_i(bit_period),
        .ready_o(tx_ready),
        .tx_o(tx_line)
    );

    // Indicators follow the state and the line levels directly
    assign serial_transmit_output_o = tx_line;
    // [RULE15] load mode lamp
    assign load_state_indicator_o = (ctl_ff == CTL_LOAD);
    // [RULE16] zeros on the lines
    assign rx_activity_indicator_o = ~serial_receive_input_i;
    assign tx_activity_indicator_o = ~tx_line;
    // [RULE17] reset lamp
    assign reset_indicator_o = ~reset_n_i;

    // [RULE19] dump byte select, word 0 LSB first
    assign tx_byte = '{valid: dump_busy_ff,
                       data: dmem_ff[dump_idx_ff[3:2]][{dump_idx_ff[1:0], 3'b000} +: 8]};

    // Controller: image load, then dump requests
    always_comb
    begin
        nxt_ctl = ctl_ff;
        nxt_load_cnt = load_cnt_ff;
        nxt_dump_busy = dump_busy_ff;
        nxt_dump_idx = dump_idx_ff;
        nxt_imem = imem_ff;
        unique case (ctl_ff)
            // [RULE1] collect image bytes
            CTL_LOAD:
            begin
                if (rx_byte.valid)
                begin
                    // [RULE9] byte lanes, word order
                    nxt_imem[load_cnt_ff[5:2]][{load_cnt_ff[1:0], 3'b000} +: 8] = rx_byte.data;
                    nxt_load_cnt = load_cnt_ff + 6'h01;
                    // [RULE3] exactly 64 bytes
                    if (load_cnt_ff == LOAD_LAST_BYTE)
                        nxt_ctl = CTL_DUMP;
                end
            end
            CTL_DUMP:
            begin
                // [RULE4] any byte received while no dump is running requests a dump
                if (rx_byte.valid && !dump_busy_ff)
                begin
                    nxt_dump_busy = 1'b1;
                    nxt_dump_idx = 4'h0;
                end
                // [RULE19] sixteen bytes, then stay
                if (dump_busy_ff && tx_ready)
                begin
                    nxt_dump_idx = dump_idx_ff + 4'h1;
                    if (dump_idx_ff == DUMP_LAST_BYTE)
                        nxt_dump_busy = 1'b0;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            ctl_ff <= CTL_LOAD;
            load_cnt_ff <= 6'h00;
            dump_busy_ff <= 1'b0;
            dump_idx_ff <= 4'h0;
            for (int i = 0; i < IMEM_WORDS; i++)
                imem_ff[i] <= 32'h0000_0000;
        end
        else if (en_i)
        begin
            ctl_ff <= nxt_ctl;
            load_cnt_ff <= nxt_load_cnt;
            dump_busy_ff <= nxt_dump_busy;
            dump_idx_ff <= nxt_dump_idx;
            imem_ff <= nxt_imem;
        end
    end

    // Core decode; one instruction per enabled cycle
    logic run;
    logic [31:0] inst, rs1_val, rs2_val, wd;
    logic [31:0] i_imm, s_imm, b_imm, u_imm, j_imm;
    logic [3:0] rs1_idx, rs2_idx, rd_idx;
    logic [6:0] opc;
    logic [2:0] f3;
    logic we, alt_imm, alt_reg;

    // [RULE20] wait for full store; halt during dump so data is coherent
    assign run = (ctl_ff == CTL_DUMP) && !dump_busy_ff;
    assign inst = imem_ff[pc_ff[5:2]];
    assign opc = inst[6:0];
    assign f3 = inst[14:12];
    // [RULE14] four-bit register indices
    assign rs1_idx = inst[18:15];
    assign rs2_idx = inst[23:20];
    assign rd_idx = inst[10:7];
    assign rs1_val = regs_ff[rs1_idx];
    assign rs2_val = regs_ff[rs2_idx];
    assign i_imm = {{20{inst[31]}}, inst[31:20]};
    assign s_imm = {{20{inst[31]}}, inst[31:25], inst[11:7]};
    assign b_imm = {{19{inst[31]}}, inst[31], inst[7], inst[30:25], inst[11:8], 1'b0};
    assign u_imm = {inst[31:12], 12'h000};
    assign j_imm = {{11{inst[31]}}, inst[31], inst[19:12], inst[20], inst[30:21], 1'b0};
    assign alt_imm = (f3 == F3_SHIFT_RIGHT) && inst[30];
    assign alt_reg = ((f3 == F3_ADD_SUB) || (f3 == F3_SHIFT_RIGHT)) && inst[30];

    // Execute, write back, data store
    always_comb
    begin
        nxt_pc = pc_ff;
        nxt_regs = regs_ff;
        nxt_dmem = dmem_ff;
        wd = 32'h0000_0000;
        we = 1'b0;
        if (run)
        begin
            nxt_pc = pc_ff + PC_STEP;
            case (opc)
                OPC_LUI:
                begin
                    we = 1'b1;
                    wd = u_imm;
                end
                OPC_AUIPC:
                begin
                    we = 1'b1;
                    wd = pc_ff + u_imm;
                end
                OPC_JAL:
                begin
                    we = 1'b1;
                    wd = pc_ff + PC_STEP;
                    nxt_pc = pc_ff + j_imm;
                end
                OPC_JALR:
                begin
                    we = 1'b1;
                    wd = pc_ff + PC_STEP;
                    nxt_pc = (rs1_val + i_imm) & ~32'h0000_0001;
                end
                OPC_BRANCH:
                begin
                    if (ulc_taken(f3, rs1_val, rs2_val))
                        nxt_pc = pc_ff + b_imm;
                end
                // [RULE12] word load, width ignored
                OPC_LOAD:
                begin
                    we = 1'b1;
                    wd = dmem_ff[2'(((rs1_val + i_imm) >> 2))];
                end
                // [RULE13] word store, width ignored
                OPC_STORE:
                begin
                    nxt_dmem[2'(((rs1_val + s_imm) >> 2))] = rs2_val;
                end
                OPC_OPIMM:
                begin
                    we = 1'b1;
                    wd = ulc_alu(f3, alt_imm, rs1_val, i_imm);
                end
                OPC_OP:
                begin
                    we = 1'b1;
                    wd = ulc_alu(f3, alt_reg, rs1_val, rs2_val);
                end
                // [RULE11] fence and system codes fall through as no-ops
                default:
                begin
                    we = 1'b0;
                end
            endcase
            if (we && (rd_idx != 4'h0))
                nxt_regs[rd_idx] = wd;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            pc_ff <= PC_RESET;
            for (int i = 0; i < REG_COUNT; i++)
                regs_ff[i] <= 32'h0000_0000;
            for (int i = 0; i < DMEM_WORDS; i++)
                dmem_ff[i] <= 32'h0000_0000;
        end
        else if (en_i)
        begin
            pc_ff <= nxt_pc;
            regs_ff <= nxt_regs;
            dmem_ff <= nxt_dmem;
        end
    end
endmodule

// ===== tb/ulc_core_top_asserts.sv
// Port checker for the serially loaded core, bound to its top module.
// Assumes one clock domain and the active-low asynchronous reset.
`timescale 1ns/1ps
module ulc_core_top_asserts (
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic reset_n_i,
    input wire logic en_i,
    // Serial link
    input wire logic serial_receive_input_i,
    input wire logic serial_transmit_output_o,
    // Indicators
    input wire logic load_state_indicator_o,
    input wire logic rx_activity_indicator_o,
    input wire logic tx_activity_indicator_o,
    input wire logic reset_indicator_o
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!reset_n_i);

    rst_ind_off_a: assert property (!reset_indicator_o)
        else $error("reset indicator high out of reset");
    rx_act_track_a: assert property (rx_activity_indicator_o == !serial_receive_input_i)
        else $error("rx activity wrong");
    tx_act_track_a: assert property (tx_activity_indicator_o == !serial_transmit_output_o)
        else $error("tx activity wrong");
    load_after_rst_a: assert property ($rose(reset_n_i) |-> load_state_indicator_o && serial_transmit_output_o)
        else $error("not in load state after reset");
    load_no_return_a: assert property (!$rose(load_state_indicator_o))
        else $error("load state re-entered");
    load_end_stop_a: assert property ($fell(load_state_indicator_o) |-> $past(serial_receive_input_i))
        else $error("load ended outside stop bit");
    // transmit only on request in dump state
    quiet_load_a: assert property (load_state_indicator_o |-> serial_transmit_output_o)
        else $error("transmit during load");
    quiet_switch_a: assert property ($fell(load_state_indicator_o) |-> serial_transmit_output_o [*8])
        else $error("transmit without request");
    // Enable low freezes the transmit line and the load indicator
    en_freeze_a: assert property (!en_i |=> $stable(serial_transmit_output_o) && $stable(load_state_indicator_o))
        else $error("state moved while disabled");

    // Main scenarios reached
    load_done_c: cover property ($fell(load_state_indicator_o));
    dump_start_c: cover property ($fell(serial_transmit_output_o));
    en_pause_c: cover property (!en_i);
endmodule

bind ulc_core_top ulc_core_top_asserts ulc_core_top_asserts_i (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .en_i(en_i),
    .serial_receive_input_i(serial_receive_input_i),
    .serial_transmit_output_o(serial_transmit_output_o),
    .load_state_indicator_o(load_state_indicator_o),
    .rx_activity_indicator_o(rx_activity_indicator_o),
    .tx_activity_indicator_o(tx_activity_indicator_o),
    .reset_indicator_o(reset_indicator_o)
);

// ===== tb/ulc_host_model.sv
// Host terminal model: sends and receives 8N1 frames at a fixed bit period.
// Assumes the device answers at the bit period that the sync byte set.
`timescale 1ns/1ps
module ulc_host_model #(parameter int P = 16) (
    // Clock
    input wire logic ref_clk_i,
    // Serial lines
    input wire logic line_in_i,
    output logic line_out_o
);
    // Idle line is high
    initial line_out_o = 1'b1;

    // start, eight bits LSB first, one stop
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++)
        begin
            @(posedge ref_clk_i);
            line_out_o <= f[i];
            repeat (P - 1) @(posedge ref_clk_i);
        end
    endtask

    // sample mid-bit, stop bit returned in bit 8
    task automatic recv(output logic [8:0] f);
        int n;
        n = 0;
        while (line_in_i !== 1'b0 && n < 4000)
        begin
            @(posedge ref_clk_i);
            n++;
        end
        repeat (P / 2) @(posedge ref_clk_i);
        for (int i = 0; i < 9; i++)
        begin
            repeat (P) @(posedge ref_clk_i);
            f[i] = line_in_i;
        end
    endtask
endmodule

// ===== tb/ulc_core_top_bench.sv
// Bench for the serially loaded core: loads a program, dumps data twice.
// Assumes the host model and checker files are compiled alongside.
`timescale 1ns/1ps
module ulc_core_top_bench;
    import ulc_pkg::*;
    localparam int P = 16;
    logic ref_clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic en_i = 1'b1;
    logic rx_line;
    logic tx_line;
    logic load_ind;
    logic rx_act;
    logic tx_act;
    logic rst_ind;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    logic [8:0] fr;
    // Word and byte stores, ecall, byte load, add, taken branch, spin; rest no-ops
    logic [31:0] prog [16] = '{0: 32'h12300093, 1: 32'h00102023, 2: 32'hfff00113,
        3: 32'h00200223, 4: 32'h00000073, 5: 32'h00000183, 6: 32'h00302423,
        7: 32'h00208233, 8: 32'h00308463, 9: 32'h00000213, 10: 32'h00402623,
        11: 32'h0000006f, default: 32'h00000033};
    // Word 3 holds the sum only if the branch skipped the clearing instruction
    logic [31:0] dmem [4] = '{32'h00000123, 32'hffffffff, 32'h00000123, 32'h00000122};

    always #5 ref_clk_i = ~ref_clk_i;

    ulc_core_top ulc_core_top_i (
        .ref_clk_i(ref_clk_i),
        .reset_n_i(reset_n_i),
        .en_i(en_i),
        .serial_receive_input_i(rx_line),
        .serial_transmit_output_o(tx_line),
        .load_state_indicator_o(load_ind),
        .rx_activity_indicator_o(rx_act),
        .tx_activity_indicator_o(tx_act),
        .reset_indicator_o(rst_ind)
    );

    ulc_host_model #(.P(P)) ulc_host_model_i (
        .ref_clk_i(ref_clk_i),
        .line_in_i(tx_line),
        .line_out_o(rx_line)
    );

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Request a dump and compare all sixteen frames as they arrive
    task automatic dump_and_check(input logic [7:0] req);
        fork
            ulc_host_model_i.send(req);
            for (int i = 0; i < 16; i++)
            begin
                ulc_host_model_i.recv(fr);
                chk("dump", {24'h1, dmem[i / 4][8 * (i % 4) +: 8]}, {23'h0, fr});
            end
        join
    endtask

    // Hang guard: about 16k cycles are needed
    always @(posedge ref_clk_i)
    begin
        cycles++;
        if (cycles == 40000)
        begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        chk("reset ind", 32'h1, {31'h0, rst_ind});
        chk("load ind", 32'h1, {31'h0, load_ind});
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        chk("reset ind", 32'h0, {31'h0, rst_ind});
        chk("rx act", 32'h0, {31'h0, rx_act});
        chk("tx act", 32'h0, {31'h0, tx_act});
        ulc_host_model_i.send(8'h55);
        for (int i = 0; i < 63; i++)
            ulc_host_model_i.send(prog[i / 4][8 * (i % 4) +: 8]);
        chk("load ind", 32'h1, {31'h0, load_ind});
        // Pause the enable while the line is idle
        en_i <= 1'b0;
        repeat (5) @(posedge ref_clk_i);
        en_i <= 1'b1;
        ulc_host_model_i.send(prog[15][31:24]);
        @(posedge ref_clk_i);
        chk("load ind", 32'h0, {31'h0, load_ind});
        repeat (20) @(posedge ref_clk_i);
        dump_and_check(8'ha7);
        dump_and_check(8'h00);
        reset_n_i <= 1'b0;
        repeat (2) @(posedge ref_clk_i);
        chk("reset ind", 32'h1, {31'h0, rst_ind});
        chk("load ind", 32'h1, {31'h0, load_ind});
        reset_n_i <= 1'b1;
        @(posedge ref_clk_i);
        report_and_stop();
    end
endmodule
